/* cdms_cfg.svh */
// Register addresses, field positions, reset values and codes of the clock block
`ifndef CDMS_CFG_SVH
`define CDMS_CFG_SVH

// Byte addresses of the registers
`define CDMS_ADDR_RATIO      32'hfffe0010
`define CDMS_ADDR_STBY       32'hfffe0408
`define CDMS_ADDR_SEC_CLK    32'hfffe0410
`define CDMS_ADDR_CONV_CLK   32'hfffe0414
`define CDMS_ADDR_STATUS     32'hfffe0418

// Divider fields of clock_ratio_control
`define CDMS_BUS_DIV_LSB     8
`define CDMS_CORE_DIV_LSB    4
`define CDMS_PERI_DIV_LSB    0

// Fields of the two dedicated clock control registers
`define CDMS_SRC_SEL_LSB     6
`define CDMS_DIV_SEL_LSB     0
`define CDMS_SRC_PLL         2'h1

// Bits of standby_control_3
`define CDMS_FLOAT_BIT       7
`define CDMS_STOP_SEC_BIT    6
`define CDMS_STOP_MAIN_BIT   5
`define CDMS_STOP_OEU_BIT    4
`define CDMS_STOP_TWS_BIT    3
`define CDMS_STOP_CONV_BIT   2

// Reset values
`define CDMS_RATIO_RST       16'h0101
`define CDMS_CLK_CTRL_RST    8'h41
`define CDMS_STBY_RST        8'h7c

// Writable bits; the rest read as zero
`define CDMS_RATIO_WMASK     16'h0777
`define CDMS_CLK_CTRL_WMASK  8'hc3
`define CDMS_STBY_WMASK      8'hfc

`endif

/* cdms_clk_div.sv */
// Tick divider: one output tick per 2**shift source ticks
`timescale 1ns/1ns
module cdms_clk_div #(
    parameter int MAX_SHIFT = 3
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    // Source and ratio
    input  wire logic                 src_tick,
    input  wire logic [1:0]           shift,
    // Divided tick
    output logic                      tick_r
);
    localparam int CNT_W = MAX_SHIFT;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] mask;

    if (MAX_SHIFT < 1 || MAX_SHIFT > 3) begin : g_bad
        $error("cdms_clk_div: MAX_SHIFT must be 1 to 3");
    end

    // Terminal count from the ratio
    always_comb begin
        mask = CNT_W'((32'd1 << shift) - 32'd1);
    end

    // Count source ticks; >= catches a ratio lowered mid-count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else if (src_tick) begin
            if (cnt_r >= mask) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // Registered output tick
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= src_tick && (cnt_r >= mask);
        end
    end
endmodule

/* cdms_clk_gate.sv */
// Module-stop gate: passes a tick only while the module is not stopped
`timescale 1ns/1ns
module cdms_clk_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Source tick and controls
    input  wire logic tick,
    input  wire logic stop,
    input  wire logic standby,
    // Gated tick and run state
    output logic      mod_tick_r,
    output logic      running_r
);
    // Only the enable is removed, so the module keeps its own state [RQ12]
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mod_tick_r <= 1'b0;
            running_r  <= 1'b0;
        end else begin
            mod_tick_r <= tick && !stop && !standby; // [RQ9]
            running_r  <= !stop && !standby;         // [RQ10]
        end
    end
endmodule

/* cdms_pkg.sv */
// Types and divider decoding shared by the clock block
package cdms_pkg;

    // Register bus handshake phases
    typedef enum logic {
        CDMS_BUS_IDLE,
        CDMS_BUS_DONE
    } cdms_bus_e;

    typedef logic [1:0] cdms_shift_t;

    // Three-bit ratio code to divide-by shift; unused codes fall back to x1
    function automatic cdms_shift_t div3_shift(input logic [2:0] code);
        cdms_shift_t s;
        s = 2'h0;
        if (code[2] == 1'b0) begin
            s = code[1:0];
        end
        return s;
    endfunction

    // Two-bit ratio code to divide-by shift: 1, 1/2, 1/4, 1/8
    function automatic cdms_shift_t div2_shift(input logic [1:0] code);
        return code;
    endfunction

endpackage

/* cdms_top.sv */
// Clock ratio control and module-stop logic with Avalon-MM registers
//
// What this block does
// [RQ1] Bus divider code 001 halves the clock
// [RQ2] Core divider code 000 passes clock undivided
// [RQ3] Peripheral divider code 001 halves the clock
// [RQ4] Second timer source 01 selects PLL clock
// [RQ5] Second timer divider 01 divides by two
// [RQ6] Converter source 01 selects PLL clock
// [RQ7] Converter divider 01 divides by two
// [RQ8] Float bit 0 holds pins in standby
// [RQ9] Stop bit 1 halts module clock supply
// [RQ10] Main timer stop bit 0 keeps it running
// [RQ11] Stop bits halt output, serial, converter clocks
// [RQ12] Stopped module keeps state, resumes when cleared
//
// The input clock is the PLL output. Divided clocks leave as one-cycle
// tick strobes on that clock, so consumers stay in one clock domain.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "cdms_cfg.svh"
module cdms_top #(
    parameter int MAX_SHIFT = 3
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Avalon-MM slave
    input  wire logic [31:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Power-down state
    input  wire logic        standby_active,
    output logic             pin_hold_r,
    output logic             pin_float_r,
    // Divided clock ticks
    output logic             core_tick,
    output logic             bus_tick,
    output logic             peri_tick,
    output logic             sec_timer_tick,
    output logic             conv_tick,
    // Gated module ticks
    output logic             sec_timer_run_tick,
    output logic             main_timer_run_tick,
    output logic             oeu_run_tick,
    output logic             tws_run_tick,
    output logic             conv_run_tick
);
    localparam int NMOD = 5;

    if (MAX_SHIFT != 3) begin : g_bad
        $error("cdms_top: ratio codes need MAX_SHIFT of 3");
    end

    // Registers
    logic [15:0] clock_ratio_control_r;
    logic [7:0]  standby_control_3_r;
    logic [7:0]  second_timer_clock_control_r;
    logic [7:0]  converter_clock_control_r;

    // Bus handshake
    cdms_pkg::cdms_bus_e bus_state_r;
    logic [31:0]         rdata_r;
    logic                req;
    logic                wr_take;
    logic                hit_ratio;
    logic                hit_stby;
    logic                hit_sec;
    logic                hit_conv;
    logic                hit_status;
    logic [31:0]         rd_value;

    // Field views
    logic [2:0] bus_divider_select;
    logic [2:0] core_divider_select;
    logic [2:0] peri_divider_select;
    logic [1:0] second_timer_source_select;
    logic [1:0] second_timer_divider_select;
    logic [1:0] converter_source_select;
    logic [1:0] converter_divider_select;
    logic       pin_float_in_standby;
    logic       stop_second_timer;
    logic       stop_main_timer;
    logic       stop_output_enable_unit;
    logic       stop_two_wire_serial;
    logic       stop_first_converter;

    // Source enables and tick wiring
    logic            sec_src;
    logic            conv_src;
    logic [NMOD-1:0] gate_in;
    logic [NMOD-1:0] gate_stop;
    logic [NMOD-1:0] gate_tick;
    logic [NMOD-1:0] gate_run;
    logic [7:0]      status;

    // Register field extraction
    assign bus_divider_select  = clock_ratio_control_r[`CDMS_BUS_DIV_LSB +: 3];
    assign core_divider_select = clock_ratio_control_r[`CDMS_CORE_DIV_LSB +: 3];
    assign peri_divider_select = clock_ratio_control_r[`CDMS_PERI_DIV_LSB +: 3];
    assign second_timer_source_select =
        second_timer_clock_control_r[`CDMS_SRC_SEL_LSB +: 2];
    assign second_timer_divider_select =
        second_timer_clock_control_r[`CDMS_DIV_SEL_LSB +: 2];
    assign converter_source_select =
        converter_clock_control_r[`CDMS_SRC_SEL_LSB +: 2];
    assign converter_divider_select =
        converter_clock_control_r[`CDMS_DIV_SEL_LSB +: 2];
    assign pin_float_in_standby    = standby_control_3_r[`CDMS_FLOAT_BIT];
    assign stop_second_timer       = standby_control_3_r[`CDMS_STOP_SEC_BIT];
    assign stop_main_timer         = standby_control_3_r[`CDMS_STOP_MAIN_BIT];
    assign stop_output_enable_unit = standby_control_3_r[`CDMS_STOP_OEU_BIT];
    assign stop_two_wire_serial    = standby_control_3_r[`CDMS_STOP_TWS_BIT];
    assign stop_first_converter    = standby_control_3_r[`CDMS_STOP_CONV_BIT];

    // Address decode; full byte address compared, no aliasing
    assign hit_ratio  = (avs_address == `CDMS_ADDR_RATIO);
    assign hit_stby   = (avs_address == `CDMS_ADDR_STBY);
    assign hit_sec    = (avs_address == `CDMS_ADDR_SEC_CLK);
    assign hit_conv   = (avs_address == `CDMS_ADDR_CONV_CLK);
    assign hit_status = (avs_address == `CDMS_ADDR_STATUS);

    // One wait cycle: data ready the cycle after the request appears
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && (bus_state_r == cdms_pkg::CDMS_BUS_IDLE);
    assign wr_take = avs_write && (bus_state_r == cdms_pkg::CDMS_BUS_DONE);
    assign avs_readdata    = rdata_r;

    // Handshake phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_state_r <= cdms_pkg::CDMS_BUS_IDLE;
        end else begin
            unique case (bus_state_r)
                cdms_pkg::CDMS_BUS_IDLE: begin
                    if (req) begin
                        bus_state_r <= cdms_pkg::CDMS_BUS_DONE;
                    end
                end
                cdms_pkg::CDMS_BUS_DONE: begin
                    bus_state_r <= cdms_pkg::CDMS_BUS_IDLE;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit_ratio) begin
            rd_value = {16'h0000, clock_ratio_control_r};
        end else if (hit_stby) begin
            rd_value = {24'h00_0000, standby_control_3_r};
        end else if (hit_sec) begin
            rd_value = {24'h00_0000, second_timer_clock_control_r};
        end else if (hit_conv) begin
            rd_value = {24'h00_0000, converter_clock_control_r};
        end else if (hit_status) begin
            rd_value = {24'h00_0000, status};
        end
    end

    // Read data captured while waitrequest is high, stands until next read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && bus_state_r == cdms_pkg::CDMS_BUS_IDLE) begin
            rdata_r <= rd_value;
        end
    end

    // Clock ratio register, byte lanes 0 and 1
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_ratio_control_r <= `CDMS_RATIO_RST;
        end else if (wr_take && hit_ratio) begin
            if (avs_byteenable[0]) begin
                clock_ratio_control_r[7:0] <= avs_writedata[7:0] & 8'(`CDMS_RATIO_WMASK);
            end
            if (avs_byteenable[1]) begin
                clock_ratio_control_r[15:8] <=
                    avs_writedata[15:8] & 8'(`CDMS_RATIO_WMASK >> 8);
            end
        end
    end

    // Standby control register, byte lane 0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            standby_control_3_r <= `CDMS_STBY_RST;
        end else if (wr_take && hit_stby && avs_byteenable[0]) begin
            standby_control_3_r <= avs_writedata[7:0] & `CDMS_STBY_WMASK;
        end
    end

    // Second timer clock control, byte lane 0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            second_timer_clock_control_r <= `CDMS_CLK_CTRL_RST;
        end else if (wr_take && hit_sec && avs_byteenable[0]) begin
            second_timer_clock_control_r <=
                avs_writedata[7:0] & `CDMS_CLK_CTRL_WMASK;
        end
    end

    // Converter clock control, byte lane 0
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            converter_clock_control_r <= `CDMS_CLK_CTRL_RST;
        end else if (wr_take && hit_conv && avs_byteenable[0]) begin
            converter_clock_control_r <=
                avs_writedata[7:0] & `CDMS_CLK_CTRL_WMASK;
        end
    end

    // Core, bus and peripheral dividers run straight off the PLL clock
    cdms_clk_div #(.MAX_SHIFT(MAX_SHIFT)) u_core_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .src_tick (1'b1),
        .shift    (cdms_pkg::div3_shift(core_divider_select)), // [RQ2]
        .tick_r   (core_tick)
    );

    cdms_clk_div #(.MAX_SHIFT(MAX_SHIFT)) u_bus_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .src_tick (1'b1),
        .shift    (cdms_pkg::div3_shift(bus_divider_select)), // [RQ1]
        .tick_r   (bus_tick)
    );

    cdms_clk_div #(.MAX_SHIFT(MAX_SHIFT)) u_peri_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .src_tick (1'b1),
        .shift    (cdms_pkg::div3_shift(peri_divider_select)), // [RQ3]
        .tick_r   (peri_tick)
    );

    // Dedicated sources: only the PLL code runs, other codes stop the clock
    assign sec_src  = (second_timer_source_select == `CDMS_SRC_PLL); // [RQ4]
    assign conv_src = (converter_source_select == `CDMS_SRC_PLL);    // [RQ6]

    cdms_clk_div #(.MAX_SHIFT(MAX_SHIFT)) u_sec_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .src_tick (sec_src),
        .shift    (cdms_pkg::div2_shift(second_timer_divider_select)), // [RQ5]
        .tick_r   (sec_timer_tick)
    );

    cdms_clk_div #(.MAX_SHIFT(MAX_SHIFT)) u_conv_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .src_tick (conv_src),
        .shift    (cdms_pkg::div2_shift(converter_divider_select)), // [RQ7]
        .tick_r   (conv_tick)
    );

    // Gate inputs: index 4 second timer, 3 main timer, 2 output enable unit,
    // 1 two-wire serial, 0 first converter
    assign gate_in = {sec_timer_tick, peri_tick, peri_tick, peri_tick, conv_tick};
    assign gate_stop = {
        stop_second_timer,       // [RQ9]
        stop_main_timer,         // [RQ10]
        stop_output_enable_unit, // [RQ11]
        stop_two_wire_serial,    // [RQ11]
        stop_first_converter     // [RQ11]
    };

    // One gate per stoppable module; standby stops all of them
    for (genvar i = 0; i < NMOD; i++) begin : g_gate
        cdms_clk_gate u_gate (
            .clk        (clk),
            .arst_n     (arst_n),
            .tick       (gate_in[i]),
            .stop       (gate_stop[i]),
            .standby    (standby_active),
            .mod_tick_r (gate_tick[i]),
            .running_r  (gate_run[i])
        );
    end

    assign sec_timer_run_tick  = gate_tick[4];
    assign main_timer_run_tick = gate_tick[3];
    assign oeu_run_tick        = gate_tick[2];
    assign tws_run_tick        = gate_tick[1];
    assign conv_run_tick       = gate_tick[0];

    // Pin state in standby: hold unless software asked for float
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_hold_r  <= 1'b0;
            pin_float_r <= 1'b0;
        end else begin
            pin_hold_r  <= standby_active && !pin_float_in_standby; // [RQ8]
            pin_float_r <= standby_active && pin_float_in_standby;
        end
    end

    // Status view of the block's own state
    assign status = {gate_run, pin_float_r, pin_hold_r, standby_active};

endmodule

/* cdms_top_monitor.sv */
// Checker for divided ticks, module stops, pin hold and bus wait
`timescale 1ns/1ns
`include "cdms_cfg.svh"
module cdms_top_monitor #(
    parameter int MAX_SHIFT = 3
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Avalon-MM slave
    input wire logic [31:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    // Power-down state
    input wire logic        standby_active,
    input wire logic        pin_hold_r,
    input wire logic        pin_float_r,
    // Ticks
    input wire logic        core_tick,
    input wire logic        bus_tick,
    input wire logic        peri_tick,
    input wire logic        sec_timer_tick,
    input wire logic        conv_tick,
    input wire logic        sec_timer_run_tick,
    input wire logic        main_timer_run_tick,
    input wire logic        oeu_run_tick,
    input wire logic        tws_run_tick,
    input wire logic        conv_run_tick
);
    logic [15:0] ratio_r;
    logic [7:0]  stby_r;
    logic [7:0]  sec_r;
    logic [7:0]  conv_r;
    logic [3:0]  quiet_r;
    logic        wr_ok;
    logic [15:0] rw;

    // Accepted write and masked ratio data
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign rw    = avs_writedata[15:0] & `CDMS_RATIO_WMASK;

    // Shadow registers, so gating can be predicted from bus traffic alone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ratio_r <= `CDMS_RATIO_RST;
            stby_r  <= `CDMS_STBY_RST;
            sec_r   <= `CDMS_CLK_CTRL_RST;
            conv_r  <= `CDMS_CLK_CTRL_RST;
        end else if (wr_ok) begin
            if (avs_address == `CDMS_ADDR_RATIO) begin
                ratio_r[7:0] <= rw[7:0];
                if (avs_byteenable[1]) ratio_r[15:8] <= rw[15:8];
            end
            if (avs_address == `CDMS_ADDR_STBY) stby_r <= avs_writedata[7:0] & `CDMS_STBY_WMASK;
            if (avs_address == `CDMS_ADDR_SEC_CLK) sec_r <= avs_writedata[7:0];
            if (avs_address == `CDMS_ADDR_CONV_CLK) conv_r <= avs_writedata[7:0];
        end
    end

    // Cycles since the last write; dividers need a few to settle after a change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) quiet_r <= 4'h0;
        else if (avs_write) quiet_r <= 4'h0;
        else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_bus_half_rate: assert property (quiet_r > 4'd11 && ratio_r[10:8] == 3'h1
        |-> bus_tick != $past(bus_tick)) else $error("bus tick not halved");
    a_core_full_rate: assert property (quiet_r > 4'd11 && ratio_r[6:4] == 3'h0
        |-> core_tick) else $error("core tick not undivided");
    a_peri_half_rate: assert property (quiet_r > 4'd11 && ratio_r[2:0] == 3'h1
        |-> peri_tick != $past(peri_tick)) else $error("peripheral tick not halved");
    a_sec_pll_half: assert property (
        quiet_r > 4'd11 && sec_r[7:6] == 2'h1 && sec_r[1:0] == 2'h1
        |-> sec_timer_tick ##1 !sec_timer_tick or !sec_timer_tick ##1 sec_timer_tick)
        else $error("second timer tick not half of clock");
    a_conv_pll_half: assert property (
        quiet_r > 4'd11 && conv_r[7:6] == 2'h1 && conv_r[1:0] == 2'h1
        |-> conv_tick != $past(conv_tick)) else $error("converter tick not half of clock");
    a_pin_hold_level: assert property (pin_hold_r == ($past(standby_active) && !$past(stby_r[7]))
        && pin_float_r == ($past(standby_active) && $past(stby_r[7])))
        else $error("pin hold state wrong");
    a_stop_sec_timer: assert property (stby_r[6] && $past(stby_r[6])
        |-> !sec_timer_run_tick) else $error("stopped second timer ticks");
    a_stop_other_units: assert property (!(stby_r[4] && $past(stby_r[4]) && oeu_run_tick)
        && !(stby_r[3] && $past(stby_r[3]) && tws_run_tick)
        && !(stby_r[2] && $past(stby_r[2]) && conv_run_tick)) else $error("stopped unit ticks");
    a_main_timer_runs: assert property (quiet_r > 4'd11 && !stby_r[5] && !standby_active
        |-> ##[0:16] (main_timer_run_tick || standby_active || stby_r[5]))
        else $error("main timer receives no tick");
    a_sec_gated_source: assert property (sec_timer_run_tick |-> $past(sec_timer_tick))
        else $error("second timer run tick without source");
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer not after one wait cycle");
endmodule

bind cdms_top cdms_top_monitor #(.MAX_SHIFT(MAX_SHIFT)) i_mon (.clk, .arst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .standby_active,
    .pin_hold_r, .pin_float_r, .core_tick, .bus_tick, .peri_tick, .sec_timer_tick, .conv_tick,
    .sec_timer_run_tick, .main_timer_run_tick, .oeu_run_tick, .tws_run_tick, .conv_run_tick);

/* clock_divider_module_stop_tb.sv */
// Self-checking bench for the clock ratio and module-stop block
`timescale 1ns/1ns
`include "cdms_cfg.svh"
module clock_divider_module_stop_tb_top;
    logic        clk;
    logic        arst_n;
    logic [31:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        standby_active;
    logic        pin_hold_r;
    logic        pin_float_r;
    logic [9:0]  ticks;
    logic [31:0] exp_q[$];
    logic [2:0]  cc;
    logic [2:0]  pc;
    int          num_errors;
    int          comparisons;
    int          n;

    cdms_top #(.MAX_SHIFT(3)) i_dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .standby_active(standby_active),
        .pin_hold_r(pin_hold_r), .pin_float_r(pin_float_r), .core_tick(ticks[0]),
        .bus_tick(ticks[1]), .peri_tick(ticks[2]), .sec_timer_tick(ticks[3]),
        .conv_tick(ticks[4]), .sec_timer_run_tick(ticks[5]), .main_timer_run_tick(ticks[6]),
        .oeu_run_tick(ticks[7]), .tws_run_tick(ticks[8]), .conv_run_tick(ticks[9]));

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon cycle; waitrequest is sampled at each rising edge, request held until it is low
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            print_verdict();
        end else begin
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Settle, then count one tick line over 64 cycles
    task automatic cnt(input int sel);
        repeat (16) @(negedge clk);
        n = 0;
        repeat (64) begin
            @(negedge clk);
            if (ticks[sel] === 1'b1) n++;
        end
    endtask

    task automatic rate(input int sel, input int exp);
        cnt(sel);
        check("tick count", 32'(n), 32'(exp));
    endtask

    // Read data watcher: takes the oldest expectation at the accepting rising edge
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
            else check("readdata", avs_readdata, exp_q.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        avs_address = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        standby_active = 1'b0;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'had275770));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values, reserved bits and an unmapped address
        rd(`CDMS_ADDR_RATIO, 32'h0101);
        rd(`CDMS_ADDR_STBY, 32'h7c);
        rd(`CDMS_ADDR_SEC_CLK, 32'h41);
        rd(`CDMS_ADDR_CONV_CLK, 32'h41);
        rd(32'hfffe0420, 32'h0);
        $display("test reset done");
        // Ratio codes, 1xx falls back to x1; core and peripheral codes random
        for (int i = 0; i < 5; i++) begin
            cc = 3'($urandom_range(3, 0));
            pc = 3'($urandom_range(3, 0));
            wr(`CDMS_ADDR_RATIO, {21'h0, 3'(i), 1'b0, cc, 1'b0, pc});
            rate(1, i == 4 ? 64 : 64 >> i);
            rate(0, 64 >> cc);
            rate(2, 64 >> pc);
        end
        wr(`CDMS_ADDR_RATIO, 32'h0101);
        // Dedicated clocks: every divider code, then a non-PLL source
        for (int i = 0; i < 5; i++) begin
            wr(`CDMS_ADDR_SEC_CLK, i == 4 ? 32'h01 : 32'h40 | i);
            wr(`CDMS_ADDR_CONV_CLK, i == 4 ? 32'h01 : 32'h40 | i);
            rate(3, i == 4 ? 0 : 64 >> i);
            rate(4, i == 4 ? 0 : 64 >> i);
        end
        wr(`CDMS_ADDR_SEC_CLK, 32'h41);
        wr(`CDMS_ADDR_CONV_CLK, 32'h41);
        $display("test ratios done");
        // Stop pattern with a reserved bit set
        wr(`CDMS_ADDR_STBY, 32'h5e);
        rd(`CDMS_ADDR_STBY, 32'h5c);
        rate(5, 0);
        cnt(6);
        check("main timer ticking", 32'(n > 0), 32'h1);
        for (int s = 7; s < 10; s++) rate(s, 0);
        rd(`CDMS_ADDR_STATUS, 32'h40);
        // Clearing the stops resumes every unit
        wr(`CDMS_ADDR_STBY, 32'h0);
        rate(5, 32);
        rate(9, 32);
        for (int s = 6; s < 9; s++) begin
            cnt(s);
            check("resumed unit ticking", 32'(n > 0), 32'h1);
        end
        rd(`CDMS_ADDR_STATUS, 32'hf8);
        rd(`CDMS_ADDR_SEC_CLK, 32'h41);
        $display("test module stop done");
        // Standby holds pins while float bit is 0, floats them when 1
        @(posedge clk);
        standby_active <= 1'b1;
        rate(6, 0);
        check("pin hold", 32'({pin_float_r, pin_hold_r}), 32'h1);
        rd(`CDMS_ADDR_STATUS, 32'h03);
        wr(`CDMS_ADDR_STBY, 32'h80);
        repeat (4) @(negedge clk);
        check("pin float", 32'({pin_float_r, pin_hold_r}), 32'h2);
        rd(`CDMS_ADDR_STATUS, 32'h05);
        @(posedge clk);
        standby_active <= 1'b0;
        wr(`CDMS_ADDR_STBY, 32'h0);
        $display("test standby done");
        // Reset in mid-run restores the register values
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(`CDMS_ADDR_STBY, 32'h7c);
        rd(`CDMS_ADDR_RATIO, 32'h0101);
        $display("test second reset done");
        print_verdict();
    end
endmodule
